/* hw/ptdec_top.sv */
// Pattern lock checker, loop code control and buffered error counter
`timescale 1ns/100ps
`default_nettype none
module ptdec_top
  import ptdec_pkg::*;
#(
  parameter int unsigned QUAL_T1   = QUAL_T1_CYC,
  parameter int unsigned QUAL_E1   = QUAL_E1_CYC,
  parameter int unsigned QUAL_AUTO = QUAL_AUTO_CYC,
  parameter int unsigned SECOND    = SECOND_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        line_data,
  input  wire logic        line_bit_en,
  input  wire logic        sys_data,
  input  wire logic        sys_bit_en,
  input  wire logic        line_bipolar_violation,
  input  wire logic        line_excess_zeroes,
  input  wire logic        system_bipolar_violation,
  input  wire logic        system_excess_zeroes,
  input  wire logic        tx_single_rail_nrz,
  input  wire logic        e1_mode,
  input  wire logic        detect_direction,
  input  wire logic        detect_invert,
  input  wire logic [1:0]  detect_select,
  input  wire logic [23:0] user_pattern_word,
  input  wire logic [1:0]  loop_up_code_length,
  input  wire logic [1:0]  loop_down_code_length,
  input  wire logic [7:0]  loop_up_code,
  input  wire logic [7:0]  loop_down_code,
  input  wire logic        auto_loopback_enable,
  input  wire logic        lock_edge_select,
  input  wire logic        loop_code_edge_select,
  input  wire logic [2:0]  count_source_select,
  input  wire logic        count_update_mode,
  input  wire logic        count_latch_trigger,
  input  wire logic        lock_change_irq_mask,
  input  wire logic        bit_error_irq_mask,
  input  wire logic        loop_up_irq_mask,
  input  wire logic        loop_down_irq_mask,
  input  wire logic        second_tick_irq_mask,
  input  wire logic        count_overflow_irq_mask,
  input  wire logic [5:0]  irq_flag_clear,
  output var  logic        pattern_lock_status,
  output var  logic        pattern_error,
  output var  logic        loop_up_seen_status,
  output var  logic        loop_down_seen_status,
  output var  logic        lock_change_irq_flag,
  output var  logic        bit_error_irq_flag,
  output var  logic        loop_up_irq_flag,
  output var  logic        loop_down_irq_flag,
  output var  logic        second_tick_irq_flag,
  output var  logic        count_overflow_irq_flag,
  output var  logic        irq_n,
  output var  logic [7:0]  count_hold_high,
  output var  logic [7:0]  count_hold_low,
  output var  logic        remote_loopback,
  output var  logic        digital_loopback
);
  ptdec_ib_if ib ();

  logic        tap_en;
  logic        tap_raw;
  logic        tap_bit;
  logic        exp_bit;
  logic        mis;
  logic        perr_now;
  logic        count_ev;
  logic        xfer;
  logic        tick;
  logic [5:0]  flag_set;
  logic [5:0]  mask;
  logic [1:0]  seen_rise;
  logic [1:0]  seen_edge;
  logic        lock_next;

  // Tap select feeds both checkers; loop codes see uninverted data
  always_comb begin
    tap_en  = detect_direction ? sys_bit_en : line_bit_en;
    tap_raw = detect_direction ? sys_data : line_data;
    tap_bit = tap_raw ^ detect_invert;
  end

  assign ib.bit_en   = tap_en;
  assign ib.bit_data = tap_raw;
  assign ib.code[0]  = loop_up_code;
  assign ib.code[1]  = loop_down_code;
  assign ib.len[0]   = loop_up_code_length;
  assign ib.len[1]   = loop_down_code_length;
  // Downstream timer compares with '>' so the status needs more than the time
  assign ib.qual[0]  = auto_loopback_enable ? QUAL_AUTO : QUAL_T1;
  assign ib.qual[1]  = auto_loopback_enable ? QUAL_AUTO :
                       (e1_mode ? QUAL_E1 : QUAL_T1);

  ptdec_inband ptdec_inband_i (
    .clk   (clk),
    .rst_n (rst_n),
    .ib    (ib.det)
  );

  // Pattern checker state
  logic [23:0] hist_ff, nxt_hist;
  logic [4:0]  arb_ph_ff, nxt_arb_ph;
  ptdec_lock_t st_ff, nxt_st;
  logic [6:0]  run_ff, nxt_run;
  logic [5:0]  win_ff, nxt_win;
  logic [2:0]  errs_ff, nxt_errs;
  logic        lock_ff;
  logic        perr_ff;

  always_comb begin
    // PRBS reference bits come from the received history, so no fixed seed is needed; the user word uses its hunted phase
    case (detect_select)
      SEL_QRSS: exp_bit = (hist_ff[13:0] == QRSS_ZEROS) ? 1'b1
                          : hist_ff[19] ^ hist_ff[16];
      SEL_P15:  exp_bit = hist_ff[14] ^ hist_ff[13];
      SEL_P11:  exp_bit = hist_ff[10] ^ hist_ff[8];
      default:  exp_bit = user_pattern_word[5'(ARB_LAST - arb_ph_ff)];
    endcase
    mis        = tap_bit != exp_bit;
    perr_now   = tap_en && mis && (st_ff == PTD_LOCK);
    nxt_hist   = hist_ff;
    nxt_arb_ph = arb_ph_ff;
    nxt_st     = st_ff;
    nxt_run    = run_ff;
    nxt_win    = win_ff;
    nxt_errs   = errs_ff;
    if (tap_en) begin
      nxt_hist = {hist_ff[22:0], tap_bit};
      // Hunting slips the word phase by one bit on each miss
      if (st_ff == PTD_LOCK || !mis) begin
        nxt_arb_ph = (arb_ph_ff == ARB_LAST) ? 5'h00 : arb_ph_ff + 5'h01;
      end
      case (st_ff)
        PTD_HUNT: begin
          // The bit after 64 clean bits locks, so lock needs more than the window
          nxt_run = mis ? 7'h00 : run_ff + 7'h01;
          if (!mis && run_ff == SYNC_RUN) begin
            nxt_st   = PTD_LOCK;
            nxt_win  = 6'h00;
            nxt_errs = 3'h0;
            nxt_run  = 7'h00;
          end
        end
        PTD_LOCK: begin
          nxt_errs = errs_ff + {2'h0, mis};
          nxt_win  = win_ff + 6'h01;
          if (nxt_errs > UNLOCK_ERRS) begin
            nxt_st   = PTD_HUNT;
            nxt_errs = 3'h0;
          end else if (win_ff == WIN_LAST) begin
            nxt_errs = 3'h0;
          end
        end
        default: nxt_st = PTD_HUNT;
      endcase
    end
    lock_next = nxt_st == PTD_LOCK;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_ff   <= 24'h000000;
      arb_ph_ff <= 5'h00;
      st_ff     <= PTD_HUNT;
      run_ff    <= 7'h00;
      win_ff    <= 6'h00;
      errs_ff   <= 3'h0;
      lock_ff   <= 1'b0;
      perr_ff   <= 1'b0;
    end else begin
      hist_ff   <= nxt_hist;
      arb_ph_ff <= nxt_arb_ph;
      st_ff     <= nxt_st;
      run_ff    <= nxt_run;
      win_ff    <= nxt_win;
      errs_ff   <= nxt_errs;
      lock_ff   <= lock_next;
      perr_ff   <= perr_now;
    end
  end

  // Error counter state
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] hold_ff, nxt_hold;
  logic [31:0] sec_ff, nxt_sec;
  logic        trig_ff;

  always_comb begin
    // Combined sources count one per cycle, not one per error kind
    case (count_source_select)
      CS_LINE_BIPOLAR_VIOLATION:  count_ev = line_bipolar_violation;
      CS_LINE_EXCESS_ZEROES:  count_ev = line_excess_zeroes;
      CS_LBOTH: count_ev = line_bipolar_violation | line_excess_zeroes;
      CS_SYSTEM_BIPOLAR_VIOLATION:  count_ev = system_bipolar_violation & ~tx_single_rail_nrz;
      CS_SYSTEM_EXCESS_ZEROES:  count_ev = system_excess_zeroes;
      CS_SBOTH: count_ev = (system_bipolar_violation | system_excess_zeroes)
                           & ~tx_single_rail_nrz;
      CS_PERR:  count_ev = perr_now;
      default:  count_ev = 1'b0;
    endcase
    // Second timer runs in both modes; only automatic mode uses its tick
    tick    = sec_ff == SECOND - 1;
    nxt_sec = tick ? 32'h0 : sec_ff + 32'h1;
    xfer    = count_update_mode ? tick
                                : (count_latch_trigger & ~trig_ff);
    nxt_hold = xfer ? cnt_ff : hold_ff;
    if (xfer) begin
      nxt_cnt = {15'h0000, count_ev};
    end else if (count_ev && cnt_ff != CNT_MAX) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= 16'h0000;
      hold_ff <= 16'h0000;
      sec_ff  <= 32'h0;
      trig_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      hold_ff <= nxt_hold;
      sec_ff  <= nxt_sec;
      // Cleared by reset, so a trigger held high through reset latches once
      trig_ff <= count_latch_trigger;
    end
  end

  // Flags, loopback control and interrupt line
  logic [5:0] flags_ff, nxt_flags;
  logic [1:0] seen_d_ff;
  logic       rlb_ff, nxt_rlb;
  logic       dlb_ff, nxt_dlb;
  logic       irq_n_ff;

  always_comb begin
    seen_rise = ib.seen & ~seen_d_ff;
    seen_edge = loop_code_edge_select ? (ib.seen ^ seen_d_ff) : seen_rise;
    flag_set          = 6'h00;
    flag_set[FL_LOCK] = lock_edge_select ? (lock_next ^ lock_ff)
                                         : (lock_next & ~lock_ff);
    flag_set[FL_BERR] = perr_now;
    flag_set[FL_UP]   = seen_edge[0];
    flag_set[FL_DOWN] = seen_edge[1];
    flag_set[FL_TICK] = tick & count_update_mode;
    // Overflow is judged on the running count, never in a transfer cycle
    flag_set[FL_OVF]  = count_ev & (cnt_ff == CNT_MAX) & ~xfer;
    // A set in the clearing cycle wins so no event is lost
    nxt_flags = flag_set | (flags_ff & ~irq_flag_clear);
    mask = {count_overflow_irq_mask, second_tick_irq_mask, loop_down_irq_mask,
            loop_up_irq_mask, bit_error_irq_mask, lock_change_irq_mask};
    nxt_rlb = rlb_ff;
    nxt_dlb = dlb_ff;
    if (!auto_loopback_enable) begin
      nxt_rlb = 1'b0;
      nxt_dlb = 1'b0;
    end else if (seen_rise[0]) begin
      nxt_rlb = rlb_ff | ~detect_direction;
      nxt_dlb = dlb_ff | detect_direction;
    end else if (seen_rise[1]) begin
      nxt_rlb = rlb_ff & detect_direction;
      nxt_dlb = dlb_ff & ~detect_direction;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_ff  <= 6'h00;
      seen_d_ff <= 2'h0;
      rlb_ff    <= 1'b0;
      dlb_ff    <= 1'b0;
      irq_n_ff  <= 1'b1;
    end else begin
      flags_ff  <= nxt_flags;
      seen_d_ff <= ib.seen;
      rlb_ff    <= nxt_rlb;
      dlb_ff    <= nxt_dlb;
      // Built from the next flags so the line moves in the same edge as a flag
      irq_n_ff  <= ~|(nxt_flags & ~mask);
    end
  end

  assign pattern_lock_status     = lock_ff;
  assign pattern_error           = perr_ff;
  assign loop_up_seen_status     = ib.seen[0];
  assign loop_down_seen_status   = ib.seen[1];
  assign lock_change_irq_flag    = flags_ff[FL_LOCK];
  assign bit_error_irq_flag      = flags_ff[FL_BERR];
  assign loop_up_irq_flag        = flags_ff[FL_UP];
  assign loop_down_irq_flag      = flags_ff[FL_DOWN];
  assign second_tick_irq_flag    = flags_ff[FL_TICK];
  assign count_overflow_irq_flag = flags_ff[FL_OVF];
  assign irq_n                   = irq_n_ff;
  assign count_hold_high         = hold_ff[15:8];
  assign count_hold_low          = hold_ff[7:0];
  assign remote_loopback         = rlb_ff;
  assign digital_loopback        = dlb_ff;
endmodule
`default_nettype wire

/* hw/ptdec_pkg.sv */
// Constants and types of the pattern detector and error counter
package ptdec_pkg;
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned QUAL_T1_MS   = 40;
  localparam int unsigned QUAL_E1_MS   = 30;
  localparam int unsigned QUAL_AUTO_MS = 5100;
  localparam int unsigned SECOND_MS    = 1000;
  localparam int unsigned QUAL_T1_CYC   = QUAL_T1_MS * CYC_PER_MS;
  localparam int unsigned QUAL_E1_CYC   = QUAL_E1_MS * CYC_PER_MS;
  localparam int unsigned QUAL_AUTO_CYC = QUAL_AUTO_MS * CYC_PER_MS;
  localparam int unsigned SECOND_CYC    = SECOND_MS * CYC_PER_MS;
  localparam logic [6:0] SYNC_RUN    = 7'h40;
  localparam logic [5:0] WIN_LAST    = 6'h3f;
  localparam logic [2:0] UNLOCK_ERRS = 3'h6;
  localparam logic [4:0] ARB_LAST    = 5'h17;
  localparam logic [13:0] QRSS_ZEROS = 14'h0000;
  localparam logic [6:0] IB_WIN_LAST = 7'h63;
  localparam logic [1:0] IB_MAX_ERRS = 2'h1;
  localparam logic [2:0] IB_BASE_LAST = 3'h4;
  localparam logic [1:0] SEL_QRSS = 2'h0;
  localparam logic [1:0] SEL_P15  = 2'h1;
  localparam logic [1:0] SEL_P11  = 2'h2;
  localparam logic [2:0] CS_LINE_BIPOLAR_VIOLATION  = 3'h0;
  localparam logic [2:0] CS_LINE_EXCESS_ZEROES  = 3'h1;
  localparam logic [2:0] CS_LBOTH = 3'h2;
  localparam logic [2:0] CS_SYSTEM_BIPOLAR_VIOLATION  = 3'h3;
  localparam logic [2:0] CS_SYSTEM_EXCESS_ZEROES  = 3'h4;
  localparam logic [2:0] CS_SBOTH = 3'h5;
  localparam logic [2:0] CS_PERR  = 3'h6;
  localparam int unsigned FL_LOCK = 0;
  localparam int unsigned FL_BERR = 1;
  localparam int unsigned FL_UP   = 2;
  localparam int unsigned FL_DOWN = 3;
  localparam int unsigned FL_TICK = 4;
  localparam int unsigned FL_OVF  = 5;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  typedef enum logic [1:0] {
    PTD_HUNT = 2'b01,
    PTD_LOCK = 2'b10
  } ptdec_lock_t;
endpackage

/* hw/ptdec_ib_if.sv */
// Signals between the top and the loop code detector
`timescale 1ns/100ps
`default_nettype none
interface ptdec_ib_if;
  logic                  bit_en;
  logic                  bit_data;
  logic [1:0][7:0]       code;
  logic [1:0][1:0]       len;
  logic [1:0][31:0]      qual;
  logic [1:0]            seen;
  modport ctl (output bit_en, bit_data, code, len, qual, input seen);
  modport det (input bit_en, bit_data, code, len, qual, output seen);
endinterface
`default_nettype wire

/* hw/ptdec_inband.sv */
// Loop-up and loop-down code detectors with qualification timers
`timescale 1ns/100ps
`default_nettype none
module ptdec_inband
  import ptdec_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  ptdec_ib_if.det   ib
);
  for (genvar g = 0; g < 2; g++) begin : g_code
    logic [2:0]  ph_ff, nxt_ph;
    logic [6:0]  win_ff, nxt_win;
    logic [1:0]  errs_ff, nxt_errs;
    logic        pres_ff, nxt_pres;
    logic [31:0] tmr_ff, nxt_tmr;
    logic        seen_ff, nxt_seen;
    logic [2:0]  last;
    logic        mis;
    logic [1:0]  errs_now;
    always_comb begin
      last     = IB_BASE_LAST + {1'b0, ib.len[g]};
      mis      = ib.bit_data != ib.code[g][3'(last - ph_ff)];
      errs_now = (errs_ff == 2'h2) ? errs_ff : errs_ff + {1'b0, mis};
      nxt_ph   = ph_ff;
      nxt_win  = win_ff;
      nxt_errs = errs_ff;
      nxt_pres = pres_ff;
      nxt_tmr  = tmr_ff;
      nxt_seen = seen_ff;
      if (ib.bit_en) begin
        // Absent code slips one bit on a miss to hunt for the phase
        if (pres_ff || !mis) begin
          nxt_ph = (ph_ff == last) ? 3'h0 : ph_ff + 3'h1;
        end
        if (win_ff == IB_WIN_LAST) begin
          nxt_pres = errs_now <= IB_MAX_ERRS;
          nxt_win  = 7'h00;
          nxt_errs = 2'h0;
        end else begin
          nxt_win  = win_ff + 7'h01;
          nxt_errs = errs_now;
        end
      end
      if (!pres_ff) begin
        nxt_tmr  = 32'h0;
        nxt_seen = 1'b0;
      end else if (tmr_ff > ib.qual[g]) begin
        nxt_seen = 1'b1;
      end else begin
        nxt_tmr = tmr_ff + 32'h1;
      end
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ph_ff   <= 3'h0;
        win_ff  <= 7'h00;
        errs_ff <= 2'h0;
        pres_ff <= 1'b0;
        tmr_ff  <= 32'h0;
        seen_ff <= 1'b0;
      end else begin
        ph_ff   <= nxt_ph;
        win_ff  <= nxt_win;
        errs_ff <= nxt_errs;
        pres_ff <= nxt_pres;
        tmr_ff  <= nxt_tmr;
        seen_ff <= nxt_seen;
      end
    end
    assign ib.seen[g] = seen_ff;
  end
endmodule
`default_nettype wire

/* bench/ptdec_line_model.sv */
// Far-side bit source: repeated 24-bit word or 2^11-1 sequence
`timescale 1ns/100ps
`default_nettype none
module ptdec_line_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        prbs,
  input  wire logic        flip,
  input  wire logic        err,
  input  wire logic [23:0] word,
  output var  logic        data,
  output var  logic        bit_en
);
  logic [4:0]  idx_ff = 5'h17;
  logic [10:0] lfsr_ff = 11'h7ff;
  logic        nb;
  initial data = 1'b0;
  initial bit_en = 1'b0;
  // x^11+x^9 so that each bit is the xor of the bits 11 and 9 back
  always_comb nb = prbs ? lfsr_ff[10] ^ lfsr_ff[8] : word[idx_ff];
  always @(posedge clk) begin
    bit_en <= run;
    // Idle line shows the inverse of the last bit, never a stale copy
    data <= run ? (nb ^ flip ^ err) : ~data;
    if (run) begin
      idx_ff <= (idx_ff == 5'h00) ? 5'h17 : idx_ff - 5'h01;
      lfsr_ff <= {lfsr_ff[9:0], nb};
    end
  end
endmodule
`default_nettype wire

/* bench/ptdec_top_sva.sv */
// Concurrent checks on the ports of ptdec_top
`timescale 1ns/100ps
`default_nettype none
module ptdec_top_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       line_bit_en,
  input wire logic       sys_bit_en,
  input wire logic       detect_direction,
  input wire logic       lock_edge_select,
  input wire logic       auto_loopback_enable,
  input wire logic       count_update_mode,
  input wire logic       count_latch_trigger,
  input wire logic       lock_change_irq_mask,
  input wire logic [5:0] irq_flag_clear,
  input wire logic       pattern_lock_status,
  input wire logic       pattern_error,
  input wire logic       loop_up_seen_status,
  input wire logic       lock_change_irq_flag,
  input wire logic       bit_error_irq_flag,
  input wire logic       loop_up_irq_flag,
  input wire logic       irq_n,
  input wire logic [7:0] count_hold_high,
  input wire logic [7:0] count_hold_low,
  input wire logic       remote_loopback,
  input wire logic       digital_loopback
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_perr_lock;
    pattern_error |-> $past(pattern_lock_status)
      && $past(detect_direction ? sys_bit_en : line_bit_en);
  endproperty
  a_perr_lock: assert property (p_perr_lock)
    else $error("pattern error without a locked bit");
  property p_perr_flag; pattern_error |-> bit_error_irq_flag; endproperty
  a_perr_flag: assert property (p_perr_flag)
    else $error("pattern error left its flag clear");
  property p_lock_rise;
    $rose(pattern_lock_status) |-> ##[0:1] lock_change_irq_flag;
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock rise left its flag clear");
  property p_lock_fall;
    $fell(pattern_lock_status) && lock_edge_select |-> ##[0:1] lock_change_irq_flag;
  endproperty
  a_lock_fall: assert property (p_lock_fall)
    else $error("lock fall left its flag clear");
  property p_sticky;
    bit_error_irq_flag && !irq_flag_clear[1] |=> bit_error_irq_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag dropped without a clear");
  property p_irq_lock;
    lock_change_irq_flag && !lock_change_irq_mask && $stable(lock_change_irq_mask) |-> !irq_n;
  endproperty
  a_irq_lock: assert property (p_irq_lock)
    else $error("unmasked lock flag without interrupt");
  property p_up_flag;
    $rose(loop_up_seen_status) |-> ##[0:1] loop_up_irq_flag;
  endproperty
  a_up_flag: assert property (p_up_flag)
    else $error("loop up status rise left its flag clear");
  property p_loop_off;
    !auto_loopback_enable |=> !remote_loopback && !digital_loopback;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loopback on while automatic loopback is off");
  // Allows one or two cycles of latency after the trigger edge
  property p_hold_manual;
    $changed({count_hold_high, count_hold_low}) && !$past(count_update_mode)
      |-> $past(count_latch_trigger)
      && (!$past(count_latch_trigger, 2) || !$past(count_latch_trigger, 3));
  endproperty
  a_hold_manual: assert property (p_hold_manual)
    else $error("held count changed without a trigger edge");
endmodule
bind ptdec_top ptdec_top_sva ptdec_top_sva_i (.*);
`default_nettype wire

/* bench/ptdec_top_bench.sv */
// Self-checking bench of the pattern detector and error counter
`timescale 1ns/100ps
`default_nettype none
module ptdec_top_bench;
  import ptdec_pkg::*;
  logic clk, rst_n, line_data, line_bit_en, sys_data, sys_bit_en;
  logic line_bipolar_violation, line_excess_zeroes;
  logic system_bipolar_violation, system_excess_zeroes;
  logic tx_single_rail_nrz, e1_mode, detect_direction, detect_invert;
  logic [1:0]  detect_select, loop_up_code_length, loop_down_code_length;
  logic [23:0] user_pattern_word, word;
  logic [7:0]  loop_up_code, loop_down_code, count_hold_high, count_hold_low;
  logic auto_loopback_enable, lock_edge_select, loop_code_edge_select;
  logic [2:0]  count_source_select;
  logic count_update_mode, count_latch_trigger, lock_change_irq_mask;
  logic bit_error_irq_mask, loop_up_irq_mask, loop_down_irq_mask;
  logic second_tick_irq_mask, count_overflow_irq_mask;
  logic [5:0]  irq_flag_clear;
  logic pattern_lock_status, pattern_error, loop_up_seen_status;
  logic loop_down_seen_status, lock_change_irq_flag, bit_error_irq_flag;
  logic loop_up_irq_flag, loop_down_irq_flag, second_tick_irq_flag;
  logic count_overflow_irq_flag, irq_n, remote_loopback, digital_loopback;
  logic run, prbs, flip, err, m_data, m_en;
  logic [15:0] ex [6] = '{16'h3, 16'h3, 16'h5, 16'h4, 16'h3, 16'h6};
  int errors, tests_run, perr_seen;
  assign line_data = m_data;
  assign sys_data = m_data;
  assign line_bit_en = m_en & ~detect_direction;
  assign sys_bit_en = m_en & detect_direction;
  // Short counts keep the run brief; expectations use these values
  ptdec_top #(.QUAL_T1(40), .QUAL_E1(30), .QUAL_AUTO(100), .SECOND(200)) ptdec_top_i (.*);
  ptdec_line_model ptdec_line_model_i (.clk(clk), .run(run), .prbs(prbs), .flip(flip),
    .err(err), .word(word), .data(m_data), .bit_en(m_en));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (pattern_error === 1'b1) perr_seen <= perr_seen + 1;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return pattern_lock_status;
      1: return loop_up_seen_status;
      2: return loop_down_seen_status;
      default: return second_tick_irq_flag;
    endcase
  endfunction
  task automatic wt(input int w, input logic v, input int lim);
    // Look first at a negedge so flags settled by the last edge are seen
    @(negedge clk);
    for (int i = 0; i < lim && pick(w) !== v; i++) @(negedge clk);
    if (pick(w) !== v) begin
      chk("wait", {15'h0000, pick(w)}, {15'h0000, v});
      end_of_test;
    end
  endtask
  task automatic clr;
    @(posedge clk) irq_flag_clear <= 6'h3f;
    @(posedge clk) irq_flag_clear <= 6'h00;
  endtask
  task automatic inject(input int n, input int gap);
    repeat (n) begin
      @(posedge clk) err <= 1'b1;
      @(posedge clk) err <= 1'b0;
      cyc(gap);
    end
    // The last errored bit reaches the checker two edges after its strobe
    cyc(2);
    @(negedge clk);
  endtask
  task automatic latch;
    @(posedge clk) count_latch_trigger <= 1'b1;
    cyc(3);
    count_latch_trigger <= 1'b0;
    @(negedge clk);
  endtask
  task automatic s_arb;
    @(posedge clk) run <= 1'b1;
    cyc(60);
    @(negedge clk);
    chk("early lock", pattern_lock_status, 1'b0);
    wt(0, 1'b1, 300);
    chk("lock flag", lock_change_irq_flag, 1'b1);
    chk("irq on lock", irq_n, 1'b0);
    @(posedge clk) lock_change_irq_mask <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk("masked irq", irq_n, 1'b1);
    clr;
    @(posedge clk) count_source_select <= 3'h6;
    inject(3, 10);
    chk("error pulses", perr_seen, 16'h3);
    chk("error flag", bit_error_irq_flag, 1'b1);
    chk("still locked", pattern_lock_status, 1'b1);
    latch;
    chk("pattern count", {count_hold_high, count_hold_low}, 16'h3);
    @(posedge clk) lock_edge_select <= 1'b1;
    clr;
    inject(13, 0);
    chk("unlock", pattern_lock_status, 1'b0);
    chk("fall flag", lock_change_irq_flag, 1'b1);
  endtask
  task automatic s_pat;
    @(posedge clk) flip <= 1'b1;
    cyc(150);
    @(negedge clk);
    chk("inverted data", pattern_lock_status, 1'b0);
    @(posedge clk) detect_invert <= 1'b1;
    wt(0, 1'b1, 400);
    @(posedge clk) {flip, detect_invert, prbs, detect_select} <= 5'h05;
    cyc(150);
    @(negedge clk);
    chk("other sequence", pattern_lock_status, 1'b0);
    @(posedge clk) detect_select <= 2'h0;
    cyc(150);
    @(negedge clk);
    chk("qrss on short sequence", pattern_lock_status, 1'b0);
    @(posedge clk) detect_select <= 2'h2;
    wt(0, 1'b1, 400);
  endtask
  task automatic cnt_round(input logic [2:0] sel, input logic nrz, input logic [15:0] exp);
    @(posedge clk) {count_source_select, tx_single_rail_nrz} <= {sel, nrz};
    latch;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) line_bipolar_violation <= c < 3;
      line_excess_zeroes <= c >= 2 && c < 5;
      system_bipolar_violation <= c < 4;
      system_excess_zeroes <= c >= 3 && c < 6;
    end
    latch;
    chk("count", {count_hold_high, count_hold_low}, exp);
  endtask
  task automatic s_cnt;
    for (int s = 0; s < 6; s++) cnt_round(s[2:0], 1'b0, ex[s]);
    cnt_round(3'h3, 1'b1, 16'h0);
    cnt_round(3'h5, 1'b1, 16'h0);
    cnt_round(3'h4, 1'b1, 16'h3);
    cnt_round(3'h0, 1'b0, 16'h3);
    @(posedge clk) line_bipolar_violation <= 1'b1;
    cyc(65536);
    line_bipolar_violation <= 1'b0;
    @(negedge clk);
    chk("overflow flag", count_overflow_irq_flag, 1'b1);
    latch;
    chk("saturated", {count_hold_high, count_hold_low}, CNT_MAX);
  endtask
  task automatic s_auto;
    @(posedge clk) count_update_mode <= 1'b1;
    clr;
    wt(3, 1'b1, 250);
    clr;
    repeat (5) begin
      @(posedge clk) line_bipolar_violation <= 1'b1;
      @(posedge clk) line_bipolar_violation <= 1'b0;
    end
    wt(3, 1'b1, 250);
    cyc(2);
    @(negedge clk);
    chk("second count", {count_hold_high, count_hold_low}, 16'h5);
    chk("tick irq", irq_n, 1'b0);
    @(posedge clk) second_tick_irq_mask <= 1'b1;
    clr;
    wt(3, 1'b1, 250);
    cyc(1);
    @(negedge clk);
    chk("tick masked", irq_n, 1'b1);
    @(posedge clk) count_update_mode <= 1'b0;
  endtask
  task automatic s_loop;
    @(posedge clk) {prbs, word} <= {1'b0, {3{8'ha5}}};
    wt(1, 1'b1, 3000);
    // Status edges reach the flags one edge later
    cyc(1);
    @(negedge clk);
    chk("up flag", loop_up_irq_flag, 1'b1);
    @(posedge clk) {loop_code_edge_select, e1_mode} <= 2'h3;
    clr;
    @(posedge clk) word <= {3{8'h3c}};
    wt(1, 1'b0, 3000);
    wt(2, 1'b1, 3000);
    cyc(1);
    @(negedge clk);
    chk("up fall flag", loop_up_irq_flag, 1'b1);
    chk("down flag", loop_down_irq_flag, 1'b1);
    @(posedge clk) {auto_loopback_enable, word} <= {1'b1, {3{8'ha5}}};
    wt(1, 1'b1, 3000);
    cyc(2);
    @(negedge clk);
    chk("remote on", remote_loopback, 1'b1);
    @(posedge clk) word <= {3{8'h3c}};
    wt(2, 1'b1, 3000);
    cyc(2);
    @(negedge clk);
    chk("remote off", remote_loopback, 1'b0);
    @(posedge clk) {detect_direction, word} <= {1'b1, {3{8'ha5}}};
    wt(1, 1'b1, 3000);
    cyc(2);
    @(negedge clk);
    chk("digital on", digital_loopback, 1'b1);
  endtask
  initial begin
    {rst_n, run, prbs, flip, err, tx_single_rail_nrz, e1_mode} = '0;
    {line_bipolar_violation, line_excess_zeroes, detect_invert} = '0;
    {system_bipolar_violation, system_excess_zeroes, detect_direction} = '0;
    {auto_loopback_enable, lock_edge_select, loop_code_edge_select} = '0;
    {count_update_mode, count_latch_trigger, lock_change_irq_mask} = '0;
    {bit_error_irq_mask, loop_up_irq_mask, loop_down_irq_mask} = '0;
    {second_tick_irq_mask, count_overflow_irq_mask, irq_flag_clear} = '0;
    {errors, tests_run, perr_seen} = '0;
    word = 24'hc3a51f;
    user_pattern_word = 24'hc3a51f;
    {detect_select, count_source_select} = 5'h1f;
    {loop_up_code_length, loop_down_code_length} = 4'hf;
    {loop_up_code, loop_down_code} = 16'ha53c;
    cyc(2);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset irq", irq_n, 1'b1);
    chk("reset hold", {count_hold_high, count_hold_low}, 16'h0);
    s_arb;
    s_pat;
    s_cnt;
    s_auto;
    s_loop;
    end_of_test;
  end
endmodule
`default_nettype wire
